// ---- sysctl_pkg.sv ----
package sysctl_pkg;

   // ***************************************************************
   // Register map
   // ***************************************************************
   localparam logic [23:0] BUS_CONFIG_ADDR = 24'h00ff00;
   localparam logic [23:0] STACK_PAGE_ADDR = 24'h00ff01;
   localparam logic [23:0] BUS_RELEASE_WAIT_CLOCK_CTRL_ADDR = 24'h00ff02;

   // ***************************************************************
   // Field positions
   // ***************************************************************
   localparam int CE_EN_LSB = 0;
   localparam int CHIP_SIZE_LSB = 4;
   localparam int BUS_MODE_LSB = 6;
   localparam int CPU_CLOCK_SWITCH_BIT = 3;
   localparam int WAIT_LSB = 4;
   localparam int BUS_RELEASE_BIT = 7;

   // ***************************************************************
   // Encodings and reset values
   // ***************************************************************
   localparam logic [1:0] MODE_512K_MAX = 2'h3;
   localparam logic [1:0] MODE_512K_MIN = 2'h2;
   localparam logic [1:0] MODE_64K = 2'h1;
   localparam logic [1:0] MODE_SINGLE = 2'h0;
   localparam logic [1:0] SIZE_64K = 2'h3;
   localparam logic [1:0] SIZE_32K = 2'h2;
   localparam logic [1:0] SIZE_16K = 2'h1;
   localparam logic [1:0] SIZE_8K = 2'h0;
   localparam logic [1:0] CHIP_SIZE_RESET = 2'h3;
   localparam logic [7:0] STACK_PAGE_RESET = 8'h00;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [3:0] CE_EN_RESET_MCU = 4'h0;
   localparam logic [3:0] CE_EN_RESET_MPU = 4'h1;

   // ***************************************************************
   // Address boundaries (24-bit byte addresses)
   // ***************************************************************
   localparam logic [23:0] A_000000 = 24'h000000;
   localparam logic [23:0] A_002000 = 24'h002000;
   localparam logic [23:0] A_004000 = 24'h004000;
   localparam logic [23:0] A_006000 = 24'h006000;
   localparam logic [23:0] A_008000 = 24'h008000;
   localparam logic [23:0] A_00a000 = 24'h00a000;
   localparam logic [23:0] A_00c000 = 24'h00c000;
   localparam logic [23:0] A_00f000 = 24'h00f000;
   localparam logic [23:0] A_010000 = 24'h010000;
   localparam logic [23:0] A_080000 = 24'h080000;
   localparam logic [23:0] A_100000 = 24'h100000;
   localparam logic [23:0] A_180000 = 24'h180000;
   localparam logic [23:0] A_200000 = 24'h200000;
   localparam logic [23:0] A_280000 = 24'h280000;

   // Wait state is half a CPU clock; the bus cycle runs on mclk edges,
   // so each half-cycle wait is one tick of the half-cycle counter.
   localparam int HALF_PER_WAIT = 1;
   // One instruction period of interrupt blocking after a page write.
   localparam int INSN_PERIOD_NS = 100;
   localparam int CLK_PERIOD_NS = 50;
   localparam logic [3:0] INSN_BLOCK_CYCLES = 4'((INSN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_T2 = 3'b001,
      ST_T3 = 3'b010,
      ST_WAIT = 3'b011,
      ST_T4 = 3'b100
   } bus_state_t;

   typedef struct packed {
      logic [23:0] addr;
      logic rd;
      logic wr;
      logic internal;
   } bus_req_t;

   typedef struct packed {
      logic [3:0] chip_sel_n;
      logic rd_n;
      logic wr_n;
      logic busy;
   } bus_strobe_t;

endpackage

// ---- sysctl.sv ----
// What this block does
// - Chip enables share pins with output port bits.
// - Enable bit one selects chip enable function.
// - Chip enable only for its external area.
// - MPU mode puts program region on enable 0.
// - 512K MCU ranges fixed per enable.
// - 512K MPU enable 0 covers two ranges.
// - Size field selects 64K range set only.
// - 64K MPU ranges per chip size.
// - 64K MCU ranges, ROM below 004000H variant.
// - 64K MCU ranges, ROM below 002000H variant.
// - Wait states equal twice wait field.
// - Each wait state is half a clock.
// - Waits go between third and fourth state.
// - No waits internal or on slow oscillator.
// - Release enable swaps request/acknowledge pins.
// - Stack page gives upper address byte.
// - Page number forms address bits above 15.
// - Interrupts blocked until both registers written.
// - Bus mode field selects bus mode.
// - Interrupts blocked one instruction after page write.
// - Enable 0 resets per MCU/MPU, others zero.
module sysctl
   import sysctl_pkg::*;
#(
   parameter logic [1:0] MPU_OPTION_MODE = 2'h3,
   parameter bit ROM_BELOW_2000 = 1'b0
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic mpu_mode,
   input wire logic [23:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire sysctl_pkg::bus_req_t cpu_req,
   input wire logic [15:0] stack_pointer,
   input wire logic stack_access,
   output logic [23:0] stack_addr,
   output logic cpu_ready,
   output sysctl_pkg::bus_strobe_t ext_bus,
   input wire logic [3:0] port_data_3x,
   output logic [3:0] output_port_pins_3x,
   input wire logic output_port_51_data,
   input wire logic bus_ack_int,
   output logic output_port_pin_51,
   input wire logic input_port_pin_11,
   output logic bus_request_n,
   output logic input_port_11_val,
   output logic irq_block
);
   import sysctl_pkg::*;

   // ***************************************************************
   // Registers
   // ***************************************************************
   logic [3:0] chip_sel_en_q;
   logic [1:0] chip_size_q;
   logic [1:0] bus_mode_q;
   logic [7:0] stack_page_q;
   logic [7:0] ctrl_q;
   logic [1:0] mode_eff;
   logic mpu_q;
   logic strap_done_q;
   logic cfg_written_q;
   logic page_written_q;
   logic [3:0] block_cnt_q;
   logic [1:0] req_sync_q;
   logic wr_cfg;
   logic wr_page;
   logic wr_ctrl;

   assign wr_cfg = reg_wr && (reg_addr == BUS_CONFIG_ADDR);
   assign wr_page = reg_wr && (reg_addr == STACK_PAGE_ADDR);
   assign wr_ctrl = reg_wr && (reg_addr == BUS_RELEASE_WAIT_CLOCK_CTRL_ADDR);

   // The MCU/MPU strap is caught after reset release, not by the reset itself.
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         mpu_q <= 1'b0;
         strap_done_q <= 1'b0;
      end else if (!strap_done_q) begin
         mpu_q <= mpu_mode;
         strap_done_q <= 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         chip_sel_en_q <= CE_EN_RESET_MCU;
         chip_size_q <= CHIP_SIZE_RESET;
         bus_mode_q <= MODE_SINGLE;
      end else if (!strap_done_q) begin
         chip_sel_en_q <= mpu_mode ? CE_EN_RESET_MPU : CE_EN_RESET_MCU;
      end else if (wr_cfg) begin
         chip_sel_en_q <= reg_wdata[CE_EN_LSB +: 4];
         chip_size_q <= reg_wdata[CHIP_SIZE_LSB +: 2];
         bus_mode_q <= reg_wdata[BUS_MODE_LSB +: 2];
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         stack_page_q <= STACK_PAGE_RESET;
      end else if (wr_page) begin
         stack_page_q <= reg_wdata;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_q <= CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl_q <= reg_wdata;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            BUS_CONFIG_ADDR: reg_rdata <= {bus_mode_q, chip_size_q, chip_sel_en_q};
            STACK_PAGE_ADDR: reg_rdata <= stack_page_q;
            BUS_RELEASE_WAIT_CLOCK_CTRL_ADDR: reg_rdata <= ctrl_q;
            default: reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // ***************************************************************
   // Interrupt blocking
   // ***************************************************************
   // Software cannot take an interrupt until the bus and stack are set up.
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         cfg_written_q <= 1'b0;
         page_written_q <= 1'b0;
         block_cnt_q <= 4'h0;
      end else begin
         if (wr_cfg) begin
            cfg_written_q <= 1'b1;
         end
         if (wr_page) begin
            page_written_q <= 1'b1;
            block_cnt_q <= INSN_BLOCK_CYCLES;
         end else if (block_cnt_q != 4'h0) begin
            block_cnt_q <= block_cnt_q - 4'h1;
         end
      end
   end

   assign irq_block = !cfg_written_q || !page_written_q || (block_cnt_q != 4'h0);

   // ***************************************************************
   // Address decoder
   // ***************************************************************
   function automatic logic in_rng(input logic [23:0] a, input logic [23:0] lo, input logic [23:0] hi);
      in_rng = (a >= lo) && (a < hi);
   endfunction

   // MPU mode cannot run single chip: the option-chosen mode stands in.
   assign mode_eff = (mpu_q && bus_mode_q == MODE_SINGLE) ? MPU_OPTION_MODE : bus_mode_q;

   logic [3:0] hit;
   always_comb begin
      logic [23:0] a;
      logic [23:0] low;
      a = cpu_req.addr;
      hit = 4'h0;
      low = ROM_BELOW_2000 ? A_002000 : A_004000;
      case (mode_eff)
         MODE_512K_MAX, MODE_512K_MIN: begin
            if (mpu_q) begin
               hit[0] = in_rng(a, A_000000, A_00f000) || in_rng(a, A_010000, A_080000);
            end else begin
               hit[0] = in_rng(a, A_200000, A_280000);
            end
            hit[1] = in_rng(a, A_080000, A_100000);
            hit[2] = in_rng(a, A_100000, A_180000);
            hit[3] = in_rng(a, A_180000, A_200000);
         end
         MODE_64K: begin
            if (mpu_q) begin
               low = A_000000;
            end
            case (chip_size_q)
               SIZE_64K: hit[0] = in_rng(a, low, A_00f000);
               SIZE_32K: begin
                  hit[0] = in_rng(a, low, A_008000);
                  hit[1] = in_rng(a, A_008000, A_00f000);
               end
               SIZE_16K: begin
                  hit[0] = in_rng(a, low, A_004000);
                  hit[1] = in_rng(a, A_004000, A_008000);
                  hit[2] = in_rng(a, A_008000, A_00c000);
                  hit[3] = in_rng(a, A_00c000, A_00f000);
               end
               default: begin
                  if (mpu_q) begin
                     hit[0] = in_rng(a, A_000000, A_002000);
                     hit[1] = in_rng(a, A_002000, A_004000);
                  end else begin
                     hit[0] = in_rng(a, A_008000, A_00a000);
                     hit[1] = ROM_BELOW_2000 ? in_rng(a, A_002000, A_004000) : in_rng(a, A_00a000, A_00c000);
                  end
                  hit[2] = in_rng(a, A_004000, A_006000);
                  hit[3] = in_rng(a, A_006000, A_008000);
               end
            endcase
         end
         default: hit = 4'h0;
      endcase
      if (cpu_req.internal) begin
         hit = 4'h0;
      end
   end

   // ***************************************************************
   // External bus cycle with wait insertion
   // ***************************************************************
   bus_state_t state_q;
   logic [3:0] wait_q;
   logic [3:0] hit_q;
   logic rd_q;
   logic wr_q;
   logic [3:0] wait_states;

   // Two half-clock states per code; a state ends on each mclk edge here.
   assign wait_states = {ctrl_q[WAIT_LSB +: 3], 1'b0};

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= ST_IDLE;
         wait_q <= 4'h0;
         hit_q <= 4'h0;
         rd_q <= 1'b0;
         wr_q <= 1'b0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if ((cpu_req.rd || cpu_req.wr) && !cpu_req.internal) begin
                  state_q <= ST_T2;
                  hit_q <= hit;
                  rd_q <= cpu_req.rd;
                  wr_q <= cpu_req.wr;
               end
            end
            ST_T2: state_q <= ST_T3;
            ST_T3: begin
               if (wait_states != 4'h0 && !ctrl_q[CPU_CLOCK_SWITCH_BIT]) begin
                  state_q <= ST_T4;
               end else if (wait_states != 4'h0) begin
                  state_q <= ST_WAIT;
                  wait_q <= wait_states - 4'(HALF_PER_WAIT);
               end else begin
                  state_q <= ST_T4;
               end
            end
            ST_WAIT: begin
               if (wait_q == 4'h0) begin
                  state_q <= ST_T4;
               end else begin
                  wait_q <= wait_q - 4'(HALF_PER_WAIT);
               end
            end
            ST_T4: begin
               state_q <= ST_IDLE;
               hit_q <= 4'h0;
               rd_q <= 1'b0;
               wr_q <= 1'b0;
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // Strobes and chip enables span T2 through T4, waits included.
   logic active;
   assign active = (state_q != ST_IDLE);
   assign ext_bus.chip_sel_n = ~(hit_q & chip_sel_en_q & {4{active}});
   assign ext_bus.rd_n = ~(rd_q && active);
   assign ext_bus.wr_n = ~(wr_q && active);
   assign ext_bus.busy = active;
   assign cpu_ready = !active || (state_q == ST_T4);

   // ***************************************************************
   // Pin sharing
   // ***************************************************************
   genvar i;
   generate
      for (i = 0; i < 4; i++) begin : g_cs
         assign output_port_pins_3x[i] = chip_sel_en_q[i] ? ext_bus.chip_sel_n[i] : port_data_3x[i];
      end
   endgenerate

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         req_sync_q <= 2'b11;
      end else begin
         req_sync_q <= {req_sync_q[0], input_port_pin_11};
      end
   end

   assign bus_request_n = ctrl_q[BUS_RELEASE_BIT] ? req_sync_q[1] : 1'b1;
   assign input_port_11_val = req_sync_q[1];
   assign output_port_pin_51 = ctrl_q[BUS_RELEASE_BIT] ? ~bus_ack_int : output_port_51_data;

   assign stack_addr = {stack_page_q, stack_pointer};
   logic unused_ok;
   assign unused_ok = stack_access;

endmodule

// ---- sysctl_properties.sv ----
module sysctl_checker
   import sysctl_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic [23:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire sysctl_pkg::bus_req_t cpu_req,
   input wire logic [15:0] stack_pointer,
   input wire logic [23:0] stack_addr,
   input wire logic cpu_ready,
   input wire sysctl_pkg::bus_strobe_t ext_bus,
   input wire logic bus_ack_int,
   input wire logic output_port_pin_51,
   input wire logic bus_request_n,
   input wire logic irq_block
);
   timeunit 1ns;
   timeprecision 1ps;
   // ***************************************************************
   // Shadow state
   // ***************************************************************
   logic [7:0] page_q;
   logic [7:0] ctrl_q;
   logic cfg_seen_q;
   logic page_seen_q;
   logic [4:0] cnt_q;
   logic act;
   logic [4:0] exp_len;
   assign act = !(ext_bus.rd_n && ext_bus.wr_n);
   // Waits only count on the fast clock, so the slow case falls back to the bare three states.
   assign exp_len = ctrl_q[3] ? 5'h02 + {1'b0, ctrl_q[6:4], 1'b0} : 5'h02;
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         page_q <= 8'h00;
         page_seen_q <= 1'b0;
      end else if (reg_wr && reg_addr == STACK_PAGE_ADDR) begin
         page_q <= reg_wdata;
         page_seen_q <= 1'b1;
      end
   end
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) cfg_seen_q <= 1'b0;
      else if (reg_wr && reg_addr == BUS_CONFIG_ADDR) cfg_seen_q <= 1'b1;
   end
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) ctrl_q <= 8'h00;
      else if (reg_wr && reg_addr == BUS_RELEASE_WAIT_CLOCK_CTRL_ADDR) ctrl_q <= reg_wdata;
   end
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) cnt_q <= 5'h00;
      else cnt_q <= act ? cnt_q + 5'h01 : 5'h00;
   end
   // ***************************************************************
   // Properties
   // ***************************************************************
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_b);
   stack_page_a: assert property (stack_addr == {page_q, stack_pointer})
      else $error("stack address does not match page and pointer");
   idle_no_select_a: assert property (!act |-> ext_bus.chip_sel_n == 4'hf)
      else $error("chip select outside an external bus cycle");
   internal_no_cycle_a: assert property (!act && cpu_req.rd && cpu_req.internal |=> !act)
      else $error("internal access started an external cycle");
   start_cycle_a: assert property (!act && cpu_req.rd && !cpu_req.internal |=> !ext_bus.rd_n && !cpu_ready)
      else $error("external read did not start its strobe");
   wait_len_a: assert property (act && cpu_ready |-> cnt_q == exp_len)
      else $error("bus cycle length differs from the wait setting");
   cycle_end_a: assert property (act && cpu_ready |=> !act && cpu_ready)
      else $error("strobes not released after the last state");
   irq_init_a: assert property (!(cfg_seen_q && page_seen_q) |-> irq_block)
      else $error("interrupts open before both setup writes");
   irq_hold_a: assert property (reg_wr && reg_addr == STACK_PAGE_ADDR |=> irq_block [*2])
      else $error("interrupts open too soon after a page write");
   release_off_a: assert property (!ctrl_q[7] [*3] |-> bus_request_n)
      else $error("bus request seen while release is off");
   ack_pin_a: assert property (ctrl_q[7] |-> output_port_pin_51 == !bus_ack_int)
      else $error("acknowledge pin does not follow the grant");
   cover property (act && cpu_ready && exp_len == 5'h10);
   cover property (cfg_seen_q && page_seen_q && !irq_block);
   cover property (!bus_request_n);
endmodule

bind sysctl sysctl_checker i_chk (.mclk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .cpu_req, .stack_pointer,
   .stack_addr, .cpu_ready, .ext_bus, .bus_ack_int, .output_port_pin_51, .bus_request_n, .irq_block);

// ---- ext_mem_model.sv ----
module ext_mem_model
   import sysctl_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire sysctl_pkg::bus_strobe_t ext_bus,
   output logic [4:0] strobe_len,
   output logic [4:0] select_len
);
   timeunit 1ns;
   timeprecision 1ps;
   logic was_act_q;
   logic act;
   assign act = !(ext_bus.rd_n && ext_bus.wr_n);
   // Both windows restart with each new strobe, so a stale length is never reported twice.
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         was_act_q <= 1'b0;
         strobe_len <= 5'h00;
         select_len <= 5'h00;
      end else begin
         was_act_q <= act;
         if (act) strobe_len <= was_act_q ? strobe_len + 5'h01 : 5'h01;
         if (act && !was_act_q) select_len <= {4'h0, ext_bus.chip_sel_n != 4'hf};
         else if (ext_bus.chip_sel_n != 4'hf) select_len <= select_len + 5'h01;
      end
   end
endmodule

// ---- tb_top.sv ----
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import sysctl_pkg::*;
   logic mclk, rst_b, reg_wr, reg_rd, cpu_ready, irq_block;
   logic [23:0] reg_addr, stack_addr;
   logic [7:0] reg_wdata, reg_rdata;
   logic [15:0] stack_pointer;
   logic [3:0] port_data_3x, pins, ce_seen;
   logic bus_ack_int, pin51, port51, pin11, bus_request_n_n;
   logic mpu, p11v;
   logic [3:0] pins_b, ce_seen_b;
   logic [4:0] strobe_len, select_len;
   bus_req_t cpu_req;
   bus_strobe_t ext_bus;
   int fail_count, samples_checked, n;

   sysctl i_dut (.mclk, .rst_b, .mpu_mode(mpu), .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cpu_req,
      .stack_pointer, .stack_access(1'b0), .stack_addr, .cpu_ready, .ext_bus, .port_data_3x,
      .output_port_pins_3x(pins), .output_port_51_data(port51), .bus_ack_int, .output_port_pin_51(pin51),
      .input_port_pin_11(pin11), .bus_request_n(bus_request_n_n), .input_port_11_val(p11v), .irq_block);
   // Second decoder variant, internal ROM ending below 002000H; only its chip select pins are watched.
   sysctl #(.ROM_BELOW_2000(1'b1)) i_dut_b (.mclk, .rst_b, .mpu_mode(mpu), .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata(), .cpu_req, .stack_pointer, .stack_access(1'b0), .stack_addr(), .cpu_ready(),
      .ext_bus(), .port_data_3x, .output_port_pins_3x(pins_b), .output_port_51_data(port51), .bus_ack_int,
      .output_port_pin_51(), .input_port_pin_11(pin11), .bus_request_n(), .input_port_11_val(), .irq_block());
   ext_mem_model i_mem (.mclk, .rst_b, .ext_bus, .strobe_len, .select_len);

   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
      samples_checked++;
      if (got !== exp) begin
         $display("unexpected %s expected %h seen %h", what, exp, got);
         fail_count++;
      end
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic wr(input logic [23:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd_chk(input logic [23:0] a, input logic [7:0] exp);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 check("register", exp, reg_rdata);
   endtask

   // The request is held until the edge after ready, as the CPU would hold it.
   task automatic bus(input logic [23:0] a, input logic intl, input logic wc);
      @(posedge mclk);
      cpu_req <= '{a, !wc, wc, intl};
      n = 0;
      do begin
         @(posedge mclk);
         #1 n++;
         if (n == 1) begin
            ce_seen = pins;
            ce_seen_b = pins_b;
         end
      end while (!cpu_ready && n < 40);
      if (n >= 40) begin
         check("ready", 24'h1, 24'h0);
         test_done();
      end
      @(posedge mclk);
      cpu_req <= '0;
      #1;
   endtask

   task automatic dec(input logic [7:0] cfg, input logic [23:0] a, input logic intl, input logic [3:0] exp);
      wr(BUS_CONFIG_ADDR, cfg);
      bus(a, intl, 1'b0);
      check("chip select pins", (exp & cfg[3:0]) | (port_data_3x & ~cfg[3:0]), ce_seen);
   endtask

   initial begin
      rst_b = 1'b0;
      {reg_wr, reg_rd, bus_ack_int, mpu, fail_count, samples_checked} = '0;
      {reg_addr, reg_wdata, cpu_req} = '0;
      {port51, pin11, stack_pointer, port_data_3x} = {2'h3, 16'h8000, 4'h5};
      repeat (10) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (2) @(posedge mclk);
      rd_chk(BUS_CONFIG_ADDR, 8'h30);
      rd_chk(STACK_PAGE_ADDR, 8'h00);
      rd_chk(BUS_RELEASE_WAIT_CLOCK_CTRL_ADDR, 8'h00);
      rd_chk(24'h00ff03, 8'h00);
      check("port pins", port_data_3x, pins);
      wr(BUS_CONFIG_ADDR, 8'hcf);
      #1 check("irq block", 1'b1, irq_block);
      wr(STACK_PAGE_ADDR, 8'h17);
      #1 check("irq hold", 1'b1, irq_block);
      n = 0;
      while (irq_block && n < 4) begin
         @(posedge mclk);
         #1 n++;
      end
      check("irq release", 1'b0, irq_block);
      check("stack address", 24'h178000, stack_addr);
      rd_chk(STACK_PAGE_ADDR, 8'h17);
      dec(8'hcf, 24'h27ffff, 1'b0, 4'he);
      dec(8'h8f, 24'h080000, 1'b0, 4'hd);
      dec(8'hff, 24'h17ffff, 1'b0, 4'hb);
      dec(8'hbf, 24'h180000, 1'b0, 4'h7);
      dec(8'hcf, 24'h280000, 1'b0, 4'hf);
      dec(8'hcf, 24'h200000, 1'b1, 4'hf);
      dec(8'hce, 24'h200000, 1'b0, 4'he);
      dec(8'h7f, 24'h004000, 1'b0, 4'he);
      dec(8'h6f, 24'h008000, 1'b0, 4'hd);
      dec(8'h5f, 24'h004000, 1'b0, 4'hd);
      dec(8'h5f, 24'h00c000, 1'b0, 4'h7);
      dec(8'h4f, 24'h008000, 1'b0, 4'he);
      dec(8'h4f, 24'h004000, 1'b0, 4'hb);
      dec(8'h4f, 24'h006000, 1'b0, 4'h7);
      dec(8'h4f, 24'h00a000, 1'b0, 4'hd);
      dec(8'h4f, 24'h002000, 1'b0, 4'hf);
      check("variant select pins", 24'hd, ce_seen_b);
      dec(8'h7f, 24'h002000, 1'b0, 4'hf);
      check("variant select pins", 24'he, ce_seen_b);
      wr(BUS_CONFIG_ADDR, 8'hcf);
      for (int w = 0; w < 8; w++) begin
         wr(BUS_RELEASE_WAIT_CLOCK_CTRL_ADDR, {1'b0, 3'(w), 4'h8});
         bus(24'h100000, 1'b0, w[0]);
         check("bus cycles", 24'(3 + 2 * w), 24'(n));
         check("strobe window", 24'(3 + 2 * w), strobe_len);
         check("select window", 24'(3 + 2 * w), select_len);
      end
      bus(24'h100000, 1'b1, 1'b0);
      check("internal cycles", 24'h1, 24'(n));
      wr(BUS_RELEASE_WAIT_CLOCK_CTRL_ADDR, 8'h70);
      bus(24'h100000, 1'b0, 1'b0);
      check("slow clock cycles", 24'h3, 24'(n));
      @(posedge mclk);
      pin11 <= 1'b0;
      bus_ack_int <= 1'b1;
      wr(BUS_RELEASE_WAIT_CLOCK_CTRL_ADDR, 8'h80);
      repeat (3) @(posedge mclk);
      #1 check("bus request", 1'b0, bus_request_n_n);
      check("acknowledge pin", 1'b0, pin51);
      wr(BUS_RELEASE_WAIT_CLOCK_CTRL_ADDR, 8'h00);
      repeat (3) @(posedge mclk);
      #1 check("bus request", 1'b1, bus_request_n_n);
      check("port pin 51", port51, pin51);
      check("port 11 value", 1'b0, p11v);
      // A second reset with the strap in processor mode, released in mid-run.
      @(posedge mclk);
      mpu <= 1'b1;
      rst_b <= 1'b0;
      repeat (3) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (2) @(posedge mclk);
      rd_chk(BUS_CONFIG_ADDR, 8'h31);
      dec(8'h01, 24'h000000, 1'b0, 4'he);
      dec(8'hcf, 24'h010000, 1'b0, 4'he);
      dec(8'hcf, 24'h00f000, 1'b0, 4'hf);
      dec(8'h4f, 24'h002000, 1'b0, 4'hd);
      dec(8'h7f, 24'h00e000, 1'b0, 4'he);
      test_done();
   end
endmodule
